// ===== design/pwg_pkg.sv
package pwg_pkg;
	localparam int PWG_ADDR_W = 8;
	localparam int PWG_DATA_W = 32;
	localparam int PWG_PROT_W = 8;
	localparam int PWG_IDX_W = 3;

	localparam logic [PWG_ADDR_W-1:0] PWG_OFS_CLEAR = 8'h00;
	localparam logic [PWG_ADDR_W-1:0] PWG_OFS_SET = 8'h04;

	// bridge 0 bit positions
	localparam int PWG_B0_POWER_MANAGER_UNIT = 1;
	localparam int PWG_B0_SYSTEM_CONTROL_UNIT = 2;
	localparam int PWG_B0_GENERIC_CLOCK_UNIT = 3;
	localparam int PWG_B0_WATCHDOG_UNIT = 4;
	localparam int PWG_B0_CALENDAR_TIMER_UNIT = 5;
	localparam int PWG_B0_EXTERNAL_INTERRUPT_UNIT = 6;
	// bridge 1 bit positions
	localparam int PWG_B1_DEBUG_SERVICE_UNIT = 1;
	localparam int PWG_B1_FLASH_CONTROLLER_UNIT = 2;
	localparam int PWG_B1_PIN_CONTROLLER_UNIT = 3;
	localparam int PWG_B1_DMA_CONTROLLER_UNIT = 4;
	localparam int PWG_B1_TRACE_BUFFER_UNIT = 6;

	localparam logic [PWG_PROT_W-1:0] PWG_B0_MASK = 8'h7e;
	localparam logic [PWG_PROT_W-1:0] PWG_B1_MASK = 8'h5e;
	localparam logic [PWG_PROT_W-1:0] PWG_B0_RESET = 8'h00;
	localparam logic [PWG_PROT_W-1:0] PWG_B1_RESET = 8'h02;

	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic debug;
		logic [PWG_ADDR_W-1:0] addr;
		logic [PWG_DATA_W-1:0] wdata;
		logic [3:0] strb;
	} pwg_apb_req_t;

	typedef struct packed {
		logic ready;
		logic slverr;
		logic [PWG_DATA_W-1:0] rdata;
	} pwg_apb_rsp_t;

	typedef struct packed {
		logic req;
		logic debug;
		logic [PWG_IDX_W-1:0] idx;
	} pwg_guard_req_t;

	typedef struct packed {
		logic grant;
		logic err;
	} pwg_guard_rsp_t;
endpackage

// ===== design/pwg_peripheral_write_guard.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: a zero written to any protect bit, clear or set register, changes nothing
// RULE2: a one written to a clear-register bit unprotects that peripheral
// RULE3: each read-back protect bit is 1 when protected, 0 when not
// RULE4: bridge 0 bits: interrupt 6, calendar 5, watchdog 4, clock 3, system_control_unit 2, power 1
// RULE5: bridge 1 bits: trace 6, dma 4, pins 3, flash 2, debug service 1
// RULE6: reset gives bridge 0 all zeros, bridge 1 only debug service bit set
// RULE7: set-register one protects; clear and set registers read one shared state
// RULE8: write to a protected peripheral is dropped and answered with an error
// RULE9: double protect or double unprotect answers the bus with an error
// RULE10: debugger accesses ignore protection completely
// RULE11: unused bits read zero and ignore writes of any size
module pwg_peripheral_write_guard
	import pwg_pkg::*;
#(
	parameter int BRIDGE = 0
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire pwg_apb_req_t apb_req_in,
	output pwg_apb_rsp_t apb_rsp_out,
	input wire pwg_guard_req_t guard_req_in,
	output pwg_guard_rsp_t guard_rsp_out,
	output logic [PWG_PROT_W-1:0] protect_out
);
	localparam logic [PWG_PROT_W-1:0] VALID_MASK = (BRIDGE == 0) ? PWG_B0_MASK : PWG_B1_MASK; // RULE4 RULE5
	localparam logic [PWG_PROT_W-1:0] RESET_VAL = (BRIDGE == 0) ? PWG_B0_RESET : PWG_B1_RESET; // RULE6

	typedef struct packed {
		logic [PWG_PROT_W-1:0] prot;
		pwg_apb_rsp_t rsp;
		pwg_guard_rsp_t grsp;
	} pwg_state_t;

	pwg_state_t state_q;
	pwg_state_t state_d;

	// byte lanes of the low byte only matter: every valid bit sits in bits 7:1
	function automatic logic [PWG_PROT_W-1:0] lane_bits(input pwg_apb_req_t r);
		lane_bits = r.strb[0] ? r.wdata[PWG_PROT_W-1:0] & VALID_MASK : '0; // RULE11
	endfunction

	logic setup;
	logic hit_clr;
	logic hit_set;
	logic [PWG_PROT_W-1:0] wbits;

	assign setup = apb_req_in.sel && !apb_req_in.enable;
	assign hit_clr = apb_req_in.addr == PWG_OFS_CLEAR;
	assign hit_set = apb_req_in.addr == PWG_OFS_SET;
	assign wbits = lane_bits(apb_req_in);

	always_comb begin
		state_d = state_q;
		state_d.rsp.ready = 1'b0;
		state_d.rsp.slverr = 1'b0;
		state_d.grsp.grant = 1'b0;
		state_d.grsp.err = 1'b0;
		if (setup) begin
			// response is registered so the access phase always completes in one cycle
			state_d.rsp.ready = 1'b1;
			state_d.rsp.rdata = '0;
			if (!(hit_clr || hit_set)) begin
				state_d.rsp.slverr = 1'b1;
			end else if (!apb_req_in.write) begin
				state_d.rsp.rdata = {{(PWG_DATA_W-PWG_PROT_W){1'b0}}, state_q.prot}; // RULE3 RULE7
			end else if (hit_clr) begin
				state_d.prot = state_q.prot & ~wbits; // RULE1 RULE2 RULE7
				// clearing an already clear bit flags a flow error unless from the debugger
				state_d.rsp.slverr = |(wbits & ~state_q.prot) && !apb_req_in.debug; // RULE9 RULE10
			end else begin
				state_d.prot = state_q.prot | wbits; // RULE1 RULE7
				state_d.rsp.slverr = |(wbits & state_q.prot) && !apb_req_in.debug; // RULE9 RULE10
			end
		end
		if (guard_req_in.req) begin
			// out-of-range or unused index is treated as unprotected
			if (state_q.prot[guard_req_in.idx] && !guard_req_in.debug) begin
				state_d.grsp.err = 1'b1; // RULE8
			end else begin
				state_d.grsp.grant = 1'b1; // RULE8 RULE10
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_q.prot <= RESET_VAL; // RULE6
			state_q.rsp <= '0;
			state_q.grsp <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign apb_rsp_out = state_q.rsp;
	assign guard_rsp_out = state_q.grsp;
	assign protect_out = state_q.prot;

	a_unused_bits_zero: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE11
		(state_q.prot & ~VALID_MASK) == '0)
		else $error("unused protect bit set");

	a_zero_write_keeps: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE1
		(setup && apb_req_in.write && (hit_clr || hit_set) && wbits == '0)
		|=> $stable(state_q.prot))
		else $error("zero write changed protection");

	a_clear_drops: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE2
		(setup && apb_req_in.write && hit_clr) |=> ((state_q.prot & $past(wbits)) == '0))
		else $error("clear write left bit set");

	a_set_raises: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE7
		(setup && apb_req_in.write && hit_set)
		|=> ((state_q.prot & $past(wbits)) == $past(wbits)))
		else $error("set write did not protect");

	a_read_mirror: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE3
		(setup && !apb_req_in.write && (hit_clr || hit_set))
		|=> apb_rsp_out.rdata == {24'h000000, $past(state_q.prot)} && apb_rsp_out.ready)
		else $error("read data does not mirror protect state");

	a_guard_blocks: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE8
		(guard_req_in.req && !guard_req_in.debug && state_q.prot[guard_req_in.idx])
		|=> guard_rsp_out.err && !guard_rsp_out.grant)
		else $error("protected write not refused");

	a_debug_bypass: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE10
		(guard_req_in.req && guard_req_in.debug) |=> guard_rsp_out.grant && !guard_rsp_out.err)
		else $error("debugger write refused");

	a_double_set_err: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE9
		(setup && apb_req_in.write && hit_set && !apb_req_in.debug
			&& |(wbits & state_q.prot)) |=> apb_rsp_out.slverr ##1 !apb_rsp_out.ready)
		else $error("double protect gave no error");

	a_reset_value: assert property (@(posedge clk_in) // RULE6
		!resetn_in |=> protect_out == RESET_VAL)
		else $error("protect state wrong after reset");

	a_reset_quiet: assert property (@(posedge clk_in) // RULE6
		!resetn_in |=> !apb_rsp_out.ready && !guard_rsp_out.grant && !guard_rsp_out.err
			&& apb_rsp_out.rdata == '0)
		else $error("responses not quiet after reset");

	a_double_clr_err: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE9
		(setup && apb_req_in.write && hit_clr && !apb_req_in.debug
			&& |(wbits & ~state_q.prot)) |=> apb_rsp_out.slverr)
		else $error("double unprotect gave no error");

	a_clean_set_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE9
		(setup && apb_req_in.write && hit_set && (wbits & state_q.prot) == '0)
		|=> !apb_rsp_out.slverr)
		else $error("fresh protect flagged as double");

	a_clean_clr_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE9
		(setup && apb_req_in.write && hit_clr && (wbits & ~state_q.prot) == '0)
		|=> !apb_rsp_out.slverr)
		else $error("fresh unprotect flagged as double");

	a_debug_reg_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE10
		(setup && apb_req_in.write && (hit_clr || hit_set) && apb_req_in.debug)
		|=> apb_rsp_out.ready && !apb_rsp_out.slverr)
		else $error("debugger register write flagged");

	// an unmapped offset answers an error so a stray pointer is caught, not silently read as zero
	a_bad_addr_err: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE7
		(setup && !(hit_clr || hit_set))
		|=> apb_rsp_out.slverr && apb_rsp_out.rdata == '0 && $stable(state_q.prot))
		else $error("unmapped access not refused");

	a_only_writes_change: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE1
		!(setup && apb_req_in.write && (hit_clr || hit_set))
		|=> $stable(state_q.prot))
		else $error("protection changed without a register write");

	a_strobe_off_keeps: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE11
		(setup && apb_req_in.write && !apb_req_in.strb[0])
		|=> $stable(state_q.prot))
		else $error("write without low lane changed protection");

	a_clear_keeps_rest: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE1
		(setup && apb_req_in.write && hit_clr)
		|=> (state_q.prot | $past(wbits)) == ($past(state_q.prot) | $past(wbits)))
		else $error("clear write touched other bits");

	a_set_keeps_rest: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE1
		(setup && apb_req_in.write && hit_set)
		|=> (state_q.prot & ~$past(wbits)) == ($past(state_q.prot) & ~$past(wbits)))
		else $error("set write touched other bits");

	a_ready_follows_setup: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE8
		setup |=> apb_rsp_out.ready)
		else $error("access phase not answered");

	a_ready_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE8
		!setup |=> !apb_rsp_out.ready && !apb_rsp_out.slverr)
		else $error("response without a setup phase");

	a_slverr_has_ready: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE9
		apb_rsp_out.slverr |-> apb_rsp_out.ready)
		else $error("error response without ready");

	a_rdata_holds: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE3
		!setup |=> $stable(apb_rsp_out.rdata))
		else $error("read data moved between accesses");

	a_guard_one_answer: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE8
		guard_req_in.req |=> guard_rsp_out.grant != guard_rsp_out.err)
		else $error("guard request not answered exactly once");

	a_guard_idle_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE8
		!guard_req_in.req |=> !guard_rsp_out.grant && !guard_rsp_out.err)
		else $error("guard answer without request");

	a_grant_has_req: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE8
		(guard_rsp_out.grant || guard_rsp_out.err) |-> $past(guard_req_in.req))
		else $error("guard answer with no request before it");

	a_guard_open_grant: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE2
		(guard_req_in.req && !state_q.prot[guard_req_in.idx]) |=> guard_rsp_out.grant)
		else $error("unprotected write refused");

	a_unused_idx_grant: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE11
		(guard_req_in.req && !VALID_MASK[guard_req_in.idx]) |=> guard_rsp_out.grant)
		else $error("unused position refused a write");
endmodule

// ===== test/pwg_bus_master.sv
`timescale 1ns/1ps
// processor or debugger attempting a peripheral write
module pwg_bus_master
	import pwg_pkg::*;
(
	input wire logic go_in,
	input wire logic dbg_in,
	input wire logic [PWG_IDX_W-1:0] idx_in,
	output pwg_guard_req_t guard_req_out
);
	// idle index is scrambled so a stale value cannot pass for a request
	assign guard_req_out = '{go_in, dbg_in, go_in ? idx_in : ~idx_in};
endmodule

// ===== test/test_peripheral_write_guard.sv
`timescale 1ns/1ps
module test_peripheral_write_guard;
	import pwg_pkg::*;
	logic clk_in = 0, resetn_in = 0, go = 0, gdbg = 0, dbg;
	logic [2:0] gidx = 0;
	logic [7:0] r = 8'h3b, prot = 8'h02, prot_o, prot0 = 8'h00, prot0_o;
	int n_errors = 0, total_checks = 0;
	pwg_apb_req_t req = '0;
	pwg_apb_rsp_t rsp, rsp0;
	pwg_guard_req_t greq;
	pwg_guard_rsp_t grsp, grsp0;
	pwg_bus_master i_bm (.go_in(go), .dbg_in(gdbg), .idx_in(gidx), .guard_req_out(greq));
	pwg_peripheral_write_guard #(.BRIDGE(1)) i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
		.apb_req_in(req), .apb_rsp_out(rsp), .guard_req_in(greq), .guard_rsp_out(grsp),
		.protect_out(prot_o));
	// bridge 0 map runs beside bridge 1 on the same bus so both bit maps are exercised
	pwg_peripheral_write_guard #(.BRIDGE(0)) i_dut_b0 (.clk_in(clk_in), .resetn_in(resetn_in),
		.apb_req_in(req), .apb_rsp_out(rsp0), .guard_req_in(greq), .guard_rsp_out(grsp0),
		.protect_out(prot0_o));
	initial forever #2.5 clk_in = ~clk_in;
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// expected answer of one bridge, worked out from the rules before the access is made
	task automatic model(inout logic [7:0] p, input logic [7:0] m, input pwg_apb_req_t q,
		output logic ex);
		logic [7:0] wb;
		wb = q.strb[0] ? q.wdata[7:0] & m : 8'h00;
		ex = q.addr != PWG_OFS_CLEAR && q.addr != PWG_OFS_SET;
		if (q.write && q.addr == PWG_OFS_SET) begin
			ex = !q.debug && (wb & p) != 8'h00;
			p = p | wb;
		end else if (q.write && q.addr == PWG_OFS_CLEAR) begin
			ex = !q.debug && (wb & ~p) != 8'h00;
			p = p & ~wb;
		end
	endtask
	task automatic apb(input logic wr, input logic db, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		pwg_apb_req_t q;
		logic e1, e0, hit;
		q = '{1'b1, 1'b0, wr, db, a, d, s};
		hit = a == PWG_OFS_CLEAR || a == PWG_OFS_SET;
		model(prot, PWG_B1_MASK, q, e1);
		model(prot0, PWG_B0_MASK, q, e0);
		@(posedge clk_in);
		req <= q;
		@(posedge clk_in);
		req.enable <= 1'b1;
		#1;
		chk(rsp.ready, 1);
		chk(rsp0.ready, 1);
		chk(rsp.slverr, e1);
		chk(rsp0.slverr, e0);
		if (!wr) begin
			chk(rsp.rdata, hit ? {24'h0, prot} : 32'h0);
			chk(rsp0.rdata, hit ? {24'h0, prot0} : 32'h0);
		end
		chk(prot_o, prot);
		chk(prot0_o, prot0);
		@(posedge clk_in);
		req <= '0;
	endtask
	task automatic grd(input logic [2:0] i, input logic db);
		@(posedge clk_in);
		go <= 1;
		gidx <= i;
		gdbg <= db;
		@(posedge clk_in);
		go <= 0;
		#1;
		chk(grsp.err, prot[i] & !db);
		chk(grsp.grant, !(prot[i] & !db));
		chk(grsp0.err, prot0[i] & !db);
		chk(grsp0.grant, !(prot0[i] & !db));
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_in);
		resetn_in <= 1;
		apb(0, 0, PWG_OFS_CLEAR, 0, 4'hf);
		apb(0, 0, PWG_OFS_SET, 0, 4'hf);
		apb(1, 0, 8'h08, 32'hff, 4'hf);
		apb(0, 0, 8'h0c, 0, 4'hf);
		for (int k = 0; k < 150; k++) begin
			r = lfsr(r);
			dbg = (k % 5 == 0);
			// the low lane is sometimes left out so narrow writes to upper bytes are covered
			apb(1, dbg, r[0] ? PWG_OFS_SET : PWG_OFS_CLEAR, {r, r, r, r},
				{3'h7, r[2] | r[4]});
			apb(0, 0, r[1] ? PWG_OFS_SET : PWG_OFS_CLEAR, 0, 4'hf);
			grd(r[3:1], dbg);
		end
		// reset in mid-run must bring both maps back to their reset values
		@(posedge clk_in);
		resetn_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		prot = PWG_B1_RESET;
		prot0 = PWG_B0_RESET;
		apb(0, 0, PWG_OFS_SET, 0, 4'hf);
		apb(0, 0, PWG_OFS_CLEAR, 0, 4'hf);
		summarize();
	end
	initial begin
		repeat (8000) @(posedge clk_in);
		n_errors++;
		summarize();
	end
endmodule
